// ===== src/cse_pkg.sv
// cse_pkg: constants for the core state and exception unit
// assumes: one core clock, 32-bit memory interface, no register bus
package cse_pkg;
    // reset vector addresses
    localparam logic [31:0] CSE_VEC_SP_ADDR = 32'h0000_0000;
    localparam logic [31:0] CSE_VEC_PC_ADDR = 32'h0000_0004;
    // status word field positions, then the control and mask word bit positions
    localparam int CSE_FLAG_N_BIT = 31;
    localparam int CSE_FLAG_Z_BIT = 30;
    localparam int CSE_FLAG_C_BIT = 29;
    localparam int CSE_FLAG_V_BIT = 28;
    localparam int CSE_STATE_BIT = 24;
    localparam int CSE_EXC_HI = 5;
    localparam int CSE_STACK_SEL_BIT = 1;
    localparam int CSE_PRIO_MASK_BIT = 0;
    // exception numbers
    localparam logic [5:0] CSE_EXC_THREAD = 6'h00;
    localparam logic [5:0] CSE_EXC_NMI = 6'h02;
    localparam logic [5:0] CSE_EXC_FATAL = 6'h03;
    localparam logic [5:0] CSE_EXC_SVC = 6'h0B;
    localparam logic [5:0] CSE_EXC_PEND = 6'h0E;
    localparam logic [5:0] CSE_EXC_TICK = 6'h0F;
    localparam logic [5:0] CSE_EXC_IRQ0 = 6'h10;
    localparam logic [5:0] CSE_EXC_CONFIG_LO = 6'h04;
    // address map region codes (upper three address bits) and unused range bounds
    localparam logic [2:0] CSE_RGN_CODE = 3'h0;
    localparam logic [2:0] CSE_RGN_DATA = 3'h1;
    localparam logic [2:0] CSE_RGN_PERI = 3'h2;
    localparam logic [31:0] CSE_UNUSED_LO = 32'h6000_0000;
    localparam logic [31:0] CSE_UNUSED_HI = 32'hDFFF_FFFF;
    // access sizes
    localparam logic [1:0] CSE_SIZE_BYTE = 2'h0;
    localparam logic [1:0] CSE_SIZE_HALF = 2'h1;
    localparam logic [1:0] CSE_SIZE_WORD = 2'h2;
    // debug comparator counts and tick width
    localparam int CSE_NUM_BKPT = 4;
    localparam int CSE_NUM_WATCH = 2;
    localparam int CSE_TICK_W = 24;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        CSE_ST_FETCH_SP = 4'h1,
        CSE_ST_FETCH_PC = 4'h2,
        CSE_ST_RUN = 4'h4,
        CSE_ST_WAIT = 4'h8
    } cse_state_type;
endpackage

// ===== src/cse_core_state.sv
// cse_core_state: architectural state, exception entry/return, faults,
// tick timer, debug comparators and the single-cycle multiplier
// assumes: memory answers fetches with mem_ready_i; instruction decode outside
`timescale 1ns/1ps
module cse_core_state #(
    parameter int NUM_IRQ = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // vector fetch on the memory interface
    output logic vec_req_o,
    output logic [31:0] vec_addr_o,
    input wire logic mem_ready_i,
    input wire logic [31:0] mem_rdata_i,
    // instruction retire from decode
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic flag_update_i,
    input wire logic [3:0] flags_i,
    // data access check
    input wire logic data_valid_i,
    input wire logic [31:0] data_addr_i,
    input wire logic [1:0] data_size_i,
    input wire logic [31:0] data_wdata_i,
    output logic [31:0] data_wdata_le_o,
    // special register writes
    input wire logic ctrl_wr_i,
    input wire logic [31:0] ctrl_wdata_i,
    input wire logic mask_wr_i,
    input wire logic [31:0] mask_wdata_i,
    // exception requests
    input wire logic nmi_i,
    input wire logic svc_i,
    input wire logic pend_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic exc_return_i,
    // tick timer control
    input wire logic tick_en_i,
    input wire logic [cse_pkg::CSE_TICK_W-1:0] tick_reload_i,
    // debug comparators
    input wire logic [31:0] bkpt_addr_i [cse_pkg::CSE_NUM_BKPT],
    input wire logic [31:0] watch_addr_i [cse_pkg::CSE_NUM_WATCH],
    output logic bkpt_hit_o,
    output logic watch_hit_o,
    // multiplier
    input wire logic [31:0] mul_a_i,
    input wire logic [31:0] mul_b_i,
    output logic [31:0] mul_p_o,
    // architectural state
    output logic [31:0] status_o,
    output logic [31:0] main_stack_ptr_o,
    output logic [31:0] pc_o,
    output logic use_process_stack_o,
    output logic handler_mode_o,
    output logic exception_priority_mask_o,
    output logic fault_o,
    output logic bus_error_o,
    output logic running_o
);
    localparam int CSE_TICK_W_P = cse_pkg::CSE_TICK_W;

    // ****************************************
    // helper decodes
    // ****************************************
    // upper address bits select the region
    function automatic logic [2:0] region(input logic [31:0] a);
        region = a[31:29];
    endfunction
    // unused range between peripherals and private block
    function automatic logic unused_rgn(input logic [31:0] a);
        unused_rgn = (a >= cse_pkg::CSE_UNUSED_LO) && (a <= cse_pkg::CSE_UNUSED_HI);
    endfunction

    // ****************************************
    // state registers
    // ****************************************
    cse_pkg::cse_state_type state, next_state;
    logic [31:0] main_stack_ptr, next_msp;
    logic [31:0] pc, next_pc;
    logic tbit, next_tbit;
    logic [3:0] flags, next_flags;
    logic [5:0] exc_num, next_exc_num;
    logic stack_sel, next_stack_sel;
    logic saved_sel, next_saved_sel;
    logic pmask, next_pmask;
    logic fault, next_fault;
    logic bus_err, next_bus_err;
    logic [CSE_TICK_W_P-1:0] tick_cnt, next_tick_cnt;
    logic tick_pend, next_tick_pend;
    logic bk_hit, next_bk_hit;
    logic wt_hit, next_wt_hit;
    logic [31:0] mul_p, next_mul_p;
    logic [31:0] wle, next_wle;

    // ****************************************
    // debug comparators
    // ****************************************
    logic [cse_pkg::CSE_NUM_BKPT-1:0] bk_match;
    logic [cse_pkg::CSE_NUM_WATCH-1:0] wt_match;
    genvar gi;
    generate
        for (gi = 0; gi < cse_pkg::CSE_NUM_BKPT; gi++)
        begin : g_bkpt
            assign bk_match[gi] = instr_valid_i && (instr_addr_i == bkpt_addr_i[gi]);
        end
        for (gi = 0; gi < cse_pkg::CSE_NUM_WATCH; gi++)
        begin : g_watch
            assign wt_match[gi] = data_valid_i && (data_addr_i == watch_addr_i[gi]);
        end
    endgenerate

    // ****************************************
    // next-state logic
    // ****************************************
    // exception decode: fault, nmi, then configurable in fixed order
    logic unaligned, exec_fault, fatal_req, cfg_req;
    logic [5:0] cfg_num;
    always_comb
    begin
        unaligned = 1'b0;
        if (data_valid_i && data_size_i == cse_pkg::CSE_SIZE_WORD)
            unaligned = |data_addr_i[1:0];
        else if (data_valid_i && data_size_i == cse_pkg::CSE_SIZE_HALF)
            unaligned = data_addr_i[0];
        // missing state bit or execution from peripheral/unused space
        exec_fault = instr_valid_i && (!tbit
            || region(instr_addr_i) == cse_pkg::CSE_RGN_PERI
            || unused_rgn(instr_addr_i));
        fatal_req = unaligned || exec_fault
            || (data_valid_i && unused_rgn(data_addr_i));
        cfg_req = 1'b0;
        cfg_num = cse_pkg::CSE_EXC_THREAD;
        if (svc_i)
        begin
            cfg_req = 1'b1;
            cfg_num = cse_pkg::CSE_EXC_SVC;
        end
        else if (pend_i)
        begin
            cfg_req = 1'b1;
            cfg_num = cse_pkg::CSE_EXC_PEND;
        end
        else if (tick_pend)
        begin
            cfg_req = 1'b1;
            cfg_num = cse_pkg::CSE_EXC_TICK;
        end
        else
        begin
            for (int k = NUM_IRQ - 1; k >= 0; k--)
                if (irq_i[k])
                begin
                    cfg_req = 1'b1;
                    cfg_num = cse_pkg::CSE_EXC_IRQ0 + 6'(k);
                end
        end
    end

    always_comb
    begin
        next_state = state;
        next_msp = main_stack_ptr;
        next_pc = pc;
        next_tbit = tbit;
        next_flags = flags;
        next_exc_num = exc_num;
        next_stack_sel = stack_sel;
        next_saved_sel = saved_sel;
        next_pmask = pmask;
        next_fault = 1'b0;
        next_bus_err = data_valid_i && unused_rgn(data_addr_i);
        next_tick_cnt = tick_cnt;
        next_tick_pend = tick_pend;
        next_bk_hit = |bk_match;
        next_wt_hit = |wt_match;
        next_mul_p = mul_a_i * mul_b_i;
        // byte 0 of the word lands at the lowest address lane
        next_wle = data_wdata_i;
        // tick countdown and reload
        if (tick_en_i)
        begin
            if (tick_cnt == '0)
            begin
                next_tick_cnt = tick_reload_i;
                next_tick_pend = 1'b1;
            end
            else
                next_tick_cnt = tick_cnt - 1'b1;
        end
        case (state)
            cse_pkg::CSE_ST_FETCH_SP:
                if (mem_ready_i)
                begin
                    next_msp = mem_rdata_i;
                    next_state = cse_pkg::CSE_ST_FETCH_PC;
                end
            cse_pkg::CSE_ST_FETCH_PC:
                if (mem_ready_i)
                begin
                    next_pc = {mem_rdata_i[31:1], 1'b0};
                    next_tbit = mem_rdata_i[0];
                    next_state = cse_pkg::CSE_ST_RUN;
                end
            cse_pkg::CSE_ST_RUN:
            begin
                if (instr_valid_i)
                    next_pc = instr_addr_i;
                if (instr_valid_i && flag_update_i)
                    next_flags = flags_i;
                if (mask_wr_i)
                    next_pmask = mask_wdata_i[cse_pkg::CSE_PRIO_MASK_BIT];
                if (ctrl_wr_i && exc_num == cse_pkg::CSE_EXC_THREAD)
                    next_stack_sel = ctrl_wdata_i[cse_pkg::CSE_STACK_SEL_BIT];
                // a fault in the same cycle wins, so it is never lost behind a return
                if (exc_return_i && exc_num != cse_pkg::CSE_EXC_THREAD && !fatal_req)
                begin
                    next_exc_num = cse_pkg::CSE_EXC_THREAD;
                    next_stack_sel = saved_sel;
                end
                else if (fatal_req || (nmi_i && exc_num != cse_pkg::CSE_EXC_NMI)
                    || (cfg_req && !pmask && exc_num == cse_pkg::CSE_EXC_THREAD))
                begin
                    if (exc_num == cse_pkg::CSE_EXC_THREAD)
                        next_saved_sel = stack_sel;
                    next_stack_sel = 1'b0;
                    next_fault = fatal_req;
                    next_exc_num = fatal_req ? cse_pkg::CSE_EXC_FATAL :
                        nmi_i ? cse_pkg::CSE_EXC_NMI : cfg_num;
                    if (!fatal_req && !nmi_i && cfg_num == cse_pkg::CSE_EXC_TICK)
                        next_tick_pend = 1'b0;
                end
            end
            cse_pkg::CSE_ST_WAIT:
                next_state = cse_pkg::CSE_ST_RUN;
            default:
                next_state = cse_pkg::CSE_ST_FETCH_SP;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= cse_pkg::CSE_ST_FETCH_SP;
            main_stack_ptr <= '0;
            pc <= '0;
            tbit <= 1'b0;
            flags <= '0;
            exc_num <= cse_pkg::CSE_EXC_THREAD;
            stack_sel <= 1'b0;
            saved_sel <= 1'b0;
            pmask <= 1'b0;
            fault <= 1'b0;
            bus_err <= 1'b0;
            tick_cnt <= '0;
            tick_pend <= 1'b0;
            bk_hit <= 1'b0;
            wt_hit <= 1'b0;
            mul_p <= '0;
            wle <= '0;
        end
        else if (clk_en_i)
        begin
            state <= next_state;
            main_stack_ptr <= next_msp;
            pc <= next_pc;
            tbit <= next_tbit;
            flags <= next_flags;
            exc_num <= next_exc_num;
            stack_sel <= next_stack_sel;
            saved_sel <= next_saved_sel;
            pmask <= next_pmask;
            fault <= next_fault;
            bus_err <= next_bus_err;
            tick_cnt <= next_tick_cnt;
            tick_pend <= next_tick_pend;
            bk_hit <= next_bk_hit;
            wt_hit <= next_wt_hit;
            mul_p <= next_mul_p;
            wle <= next_wle;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign vec_req_o = (state == cse_pkg::CSE_ST_FETCH_SP) || (state == cse_pkg::CSE_ST_FETCH_PC);
    assign vec_addr_o = (state == cse_pkg::CSE_ST_FETCH_PC) ? cse_pkg::CSE_VEC_PC_ADDR
        : cse_pkg::CSE_VEC_SP_ADDR;
    // status word: flags, state bit, exception number, reserved zero
    assign status_o = {flags, 3'h0, tbit, 18'h0, exc_num};
    assign main_stack_ptr_o = main_stack_ptr;
    assign pc_o = pc;
    assign use_process_stack_o = stack_sel && (exc_num == cse_pkg::CSE_EXC_THREAD);
    assign handler_mode_o = exc_num != cse_pkg::CSE_EXC_THREAD;
    assign exception_priority_mask_o = pmask;
    assign fault_o = fault;
    assign bus_error_o = bus_err;
    assign running_o = state == cse_pkg::CSE_ST_RUN;
    assign bkpt_hit_o = bk_hit;
    assign watch_hit_o = wt_hit;
    assign mul_p_o = mul_p;
    assign data_wdata_le_o = wle;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_pc_fetch;
        clk_en_i && state == cse_pkg::CSE_ST_FETCH_PC && mem_ready_i;
    endsequence

    a_vec_pc_load: assert property (s_pc_fetch |=> pc == {$past(mem_rdata_i[31:1]), 1'b0})
        else $error("pc not loaded from reset vector");
    a_tbit_copy: assert property (s_pc_fetch
        |=> status_o[cse_pkg::CSE_STATE_BIT] == $past(mem_rdata_i[0]))
        else $error("state bit not copied from vector");
    a_tbit_fault: assert property (clk_en_i && running_o && instr_valid_i && !tbit
        |=> fault_o && status_o[5:0] == cse_pkg::CSE_EXC_FATAL)
        else $error("missing fatal fault on clear state bit");
    a_handler_msp: assert property (handler_mode_o |-> !stack_sel && !use_process_stack_o)
        else $error("handler mode uses process stack");
    a_mask_block: assert property (clk_en_i && running_o && pmask && !handler_mode_o
        && !fatal_req && !nmi_i && !mask_wr_i && !exc_return_i |=> !handler_mode_o)
        else $error("masked exception taken");
    a_flags_hold: assert property (clk_en_i && !(instr_valid_i && flag_update_i)
        |=> $stable(status_o[31:28]))
        else $error("flags changed without qualifier");
    a_unaligned_word: assert property (clk_en_i && running_o && data_valid_i
        && data_size_i == cse_pkg::CSE_SIZE_WORD && data_addr_i[1:0] != 2'h0
        |=> fault_o)
        else $error("unaligned word without fault");
    a_mul_result: assert property (clk_en_i |=> mul_p_o == 32'($past(mul_a_i) * $past(mul_b_i)))
        else $error("multiply result wrong");
    a_bus_err: assert property (clk_en_i && data_valid_i && data_addr_i[31:29] == 3'h3
        |=> bus_error_o)
        else $error("no bus error in unused space");
endmodule

// ===== bench/cse_mem_model.sv
// cse_mem_model: memory side answering the reset vector fetch
// assumes: vec_req_i held until mem_ready_o is seen at a rising edge
`timescale 1ns/1ps
module cse_mem_model #(
    parameter logic [31:0] SP_VAL = 32'h2000_1000,
    parameter logic [31:0] PC_VAL = 32'h0000_0101,
    parameter int DELAY = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // vector fetch
    input wire logic vec_req_i,
    input wire logic [31:0] vec_addr_i,
    output logic mem_ready_o,
    output logic [31:0] mem_rdata_o
);
    // ***************************************************
    // vector table at address zero, slow answer
    // ***************************************************
    int cnt;
    int boots;
    logic [31:0] last;
    logic [31:0] answer;
    // later boots clear bit 0 of the pc vector so the state-bit fault is reachable
    assign answer = (vec_addr_i == 32'h0000_0004)
        ? ((boots == 0) ? PC_VAL : {PC_VAL[31:1], 1'b0}) : SP_VAL;
    initial
    begin
        cnt = 0;
        last = 32'h0000_0000;
        mem_ready_o = 1'b0;
        mem_rdata_o = 32'hFFFF_FFFF;
    end
    // stall DELAY cycles, then one ready cycle; idle bus shows inverted data
    always @(negedge clk_i)
    begin
        mem_ready_o <= 1'b0;
        mem_rdata_o <= ~last;
        if (!reset_n_i || !vec_req_i || mem_ready_o)
            cnt <= 0;
        else if (cnt < DELAY)
            cnt <= cnt + 1;
        else
        begin
            mem_ready_o <= 1'b1;
            last <= answer;
            mem_rdata_o <= answer;
            if (vec_addr_i == 32'h0000_0004)
                boots <= boots + 1;
        end
    end
endmodule

// ===== bench/cse_core_state_tb.sv
// cse_core_state_tb: directed sequences on the core state unit
// assumes: cse_mem_model answers the vector fetch
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module cse_core_state_tb;
    localparam logic [31:0] SP_V = 32'h2000_1000;
    localparam logic [31:0] PC_V = 32'h0000_0101;
    logic clk_i, reset_n_i, clk_en_i, vec_req_o, mem_ready_i, instr_valid_i, flag_update_i;
    logic [31:0] vec_addr_o, mem_rdata_i, instr_addr_i, data_addr_i, data_wdata_i;
    logic [31:0] data_wdata_le_o, ctrl_wdata_i, mask_wdata_i, mul_a_i, mul_b_i, mul_p_o;
    logic [31:0] status_o, main_stack_ptr_o, pc_o;
    logic [3:0] flags_i;
    logic [1:0] data_size_i;
    logic data_valid_i, ctrl_wr_i, mask_wr_i, nmi_i, svc_i, pend_i, exc_return_i, tick_en_i;
    logic [31:0] irq_i;
    logic [23:0] tick_reload_i;
    logic [31:0] bk [cse_pkg::CSE_NUM_BKPT];
    logic [31:0] wa [cse_pkg::CSE_NUM_WATCH];
    logic bkpt_hit_o, watch_hit_o, use_process_stack_o, handler_mode_o;
    logic exception_priority_mask_o, fault_o, bus_error_o, running_o;
    logic saw_fault, saw_berr, saw_bk, saw_wa;
    logic [31:0] fetched [$];
    int errors, n_checks, cycles, t0;
    cse_mem_model #(.SP_VAL(SP_V), .PC_VAL(PC_V), .DELAY(2)) cse_mem_model_i (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .vec_req_i(vec_req_o), .vec_addr_i(vec_addr_o),
        .mem_ready_o(mem_ready_i), .mem_rdata_o(mem_rdata_i));
    cse_core_state cse_core_state_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .mem_ready_i(mem_ready_i),
        .mem_rdata_i(mem_rdata_i), .instr_valid_i(instr_valid_i), .instr_addr_i(instr_addr_i),
        .flag_update_i(flag_update_i), .flags_i(flags_i), .data_valid_i(data_valid_i),
        .data_addr_i(data_addr_i), .data_size_i(data_size_i), .data_wdata_i(data_wdata_i),
        .data_wdata_le_o(data_wdata_le_o), .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
        .mask_wr_i(mask_wr_i), .mask_wdata_i(mask_wdata_i), .nmi_i(nmi_i), .svc_i(svc_i),
        .pend_i(pend_i), .irq_i(irq_i), .exc_return_i(exc_return_i), .tick_en_i(tick_en_i),
        .tick_reload_i(tick_reload_i), .bkpt_addr_i(bk), .watch_addr_i(wa),
        .bkpt_hit_o(bkpt_hit_o), .watch_hit_o(watch_hit_o), .mul_a_i(mul_a_i),
        .mul_b_i(mul_b_i), .mul_p_o(mul_p_o), .status_o(status_o),
        .main_stack_ptr_o(main_stack_ptr_o), .pc_o(pc_o),
        .use_process_stack_o(use_process_stack_o), .handler_mode_o(handler_mode_o),
        .exception_priority_mask_o(exception_priority_mask_o), .fault_o(fault_o),
        .bus_error_o(bus_error_o), .running_o(running_o));
    // ***************************************************
    // clock, monitors and timeout
    // ***************************************************
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // remember one-cycle pulses and the fetched vector addresses
    always @(posedge clk_i)
    begin
        cycles++;
        if (fault_o === 1'b1) saw_fault <= 1'b1;
        if (bus_error_o === 1'b1) saw_berr <= 1'b1;
        if (bkpt_hit_o === 1'b1) saw_bk <= 1'b1;
        if (watch_hit_o === 1'b1) saw_wa <= 1'b1;
        if (reset_n_i && vec_req_o && mem_ready_i) fetched.push_back(vec_addr_o);
        if (cycles == 5000)
        begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // bounded wait for the active exception number
    task automatic wait_exc(input logic [5:0] exp);
        int k;
        k = 0;
        while (status_o[5:0] !== exp && k < 20)
        begin
            tick(1);
            k++;
        end
        `CHK("exception number", exp, status_o[5:0])
    endtask
    task automatic ret();
        exc_return_i = 1'b1;
        tick(1);
        exc_return_i = 1'b0;
        wait_exc(cse_pkg::CSE_EXC_THREAD);
    endtask
    task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [31:0] d);
        data_valid_i = 1'b1;
        data_addr_i = a;
        data_size_i = s;
        data_wdata_i = d;
        tick(1);
        data_valid_i = 1'b0;
        tick(1);
    endtask
    // ***************************************************
    // test sequence
    // ***************************************************
    initial
    begin
        {errors, n_checks, cycles} = '0;
        {saw_fault, saw_berr, saw_bk, saw_wa} = 4'h0;
        {instr_valid_i, flag_update_i, data_valid_i, ctrl_wr_i, mask_wr_i} = 5'h00;
        {nmi_i, svc_i, pend_i, exc_return_i, tick_en_i} = 5'h00;
        {instr_addr_i, data_addr_i, data_wdata_i, ctrl_wdata_i, mask_wdata_i} = '0;
        {mul_a_i, mul_b_i, irq_i} = '0;
        {flags_i, data_size_i, tick_reload_i} = '0;
        bk = '{32'h0000_0200, 32'h0000_0300, 32'h0000_0400, 32'h0000_0100};
        wa = '{32'h2000_0040, 32'h2000_0010};
        clk_en_i = 1'b1;
        reset_n_i = 1'b0;
        tick(3);
        reset_n_i = 1'b1;
        `CHK("mask at reset", 1'b0, exception_priority_mask_o)
        `CHK("stack select at reset", 1'b0, use_process_stack_o)
        `CHK("number at reset", 6'h00, status_o[5:0])
        tick(20);
        `CHK("running", 1'b1, running_o)
        `CHK("first fetch", 32'h0000_0000, fetched[0])
        `CHK("second fetch", 32'h0000_0004, fetched[1])
        `CHK("main stack", SP_V, main_stack_ptr_o)
        `CHK("program counter", PC_V[31:1], pc_o[31:1])
        `CHK("state bit", PC_V[0], status_o[24])
        $display("test reset done");
        // flags only with the qualifier; breakpoint and watchpoint; byte lanes
        instr_valid_i = 1'b1;
        instr_addr_i = 32'h0000_0100;
        flag_update_i = 1'b1;
        flags_i = 4'hA;
        tick(1);
        flag_update_i = 1'b0;
        flags_i = 4'h5;
        tick(1);
        instr_valid_i = 1'b0;
        acc(32'h2000_0010, cse_pkg::CSE_SIZE_WORD, 32'h1122_3344);
        tick(2);
        `CHK("flags", 4'hA, status_o[31:28])
        `CHK("reserved bits", 18'h00000, status_o[23:6])
        `CHK("breakpoint", 1'b1, saw_bk)
        `CHK("watchpoint", 1'b1, saw_wa)
        `CHK("low lane", 8'h44, data_wdata_le_o[7:0])
        `CHK("high lane", 8'h11, data_wdata_le_o[31:24])
        $display("test flags done");
        // stack select in thread and handler mode
        ctrl_wr_i = 1'b1;
        ctrl_wdata_i = 32'h0000_0002;
        tick(1); // barrier cycle before the new select is relied on
        ctrl_wr_i = 1'b0;
        `CHK("process stack", 1'b1, use_process_stack_o)
        svc_i = 1'b1;
        tick(1);
        svc_i = 1'b0;
        wait_exc(cse_pkg::CSE_EXC_SVC);
        `CHK("handler", 1'b1, handler_mode_o)
        `CHK("main in handler", 1'b0, use_process_stack_o)
        ctrl_wr_i = 1'b1;
        ctrl_wdata_i = 32'h0000_0002; // ignored in handler mode
        tick(1);
        ctrl_wr_i = 1'b0;
        ret();
        `CHK("restored select", 1'b1, use_process_stack_o)
        $display("test stack done");
        // priority mask blocks configurable, not the non-maskable one
        mask_wr_i = 1'b1;
        mask_wdata_i = 32'h0000_0001;
        tick(1);
        mask_wr_i = 1'b0;
        `CHK("mask set", 1'b1, exception_priority_mask_o)
        pend_i = 1'b1;
        tick(5);
        `CHK("pend blocked", 6'h00, status_o[5:0])
        nmi_i = 1'b1;
        tick(1);
        nmi_i = 1'b0;
        wait_exc(cse_pkg::CSE_EXC_NMI);
        pend_i = 1'b0;
        ret();
        mask_wr_i = 1'b1;
        mask_wdata_i = 32'h0000_0000;
        tick(1);
        mask_wr_i = 1'b0;
        $display("test mask done");
        // alignment, unused range, execution regions
        saw_fault = 1'b0;
        acc(32'h2000_0003, cse_pkg::CSE_SIZE_BYTE, 32'h0000_00FF);
        acc(32'h2000_0004, cse_pkg::CSE_SIZE_HALF, 32'h0000_FFFF);
        tick(3);
        `CHK("aligned ok", 1'b0, saw_fault)
        acc(32'h2000_0002, cse_pkg::CSE_SIZE_WORD, 32'h0);
        wait_exc(cse_pkg::CSE_EXC_FATAL);
        `CHK("fault pulse", 1'b1, saw_fault)
        ret();
        acc(32'h6000_0000, cse_pkg::CSE_SIZE_BYTE, 32'h0);
        wait_exc(cse_pkg::CSE_EXC_FATAL);
        `CHK("bus error", 1'b1, saw_berr)
        ret();
        instr_valid_i = 1'b1;
        instr_addr_i = 32'h2000_0000;
        tick(1);
        instr_valid_i = 1'b0;
        tick(3);
        `CHK("exec data region", 6'h00, status_o[5:0])
        instr_valid_i = 1'b1;
        instr_addr_i = 32'h4000_0000;
        tick(1);
        instr_valid_i = 1'b0;
        wait_exc(cse_pkg::CSE_EXC_FATAL);
        ret();
        $display("test faults done");
        // single-cycle multiply, then the tick countdown
        mul_a_i = 32'h0001_0001;
        mul_b_i = 32'h0001_0003;
        tick(1);
        `CHK("product", 32'h0004_0003, mul_p_o)
        tick_reload_i = 24'h000005;
        tick_en_i = 1'b1;
        wait_exc(cse_pkg::CSE_EXC_TICK);
        // entries come reload plus one cycles apart, one of them spent returning
        ret();
        t0 = cycles;
        wait_exc(cse_pkg::CSE_EXC_TICK);
        `CHK("tick period", 32'h0000_0005, cycles - t0)
        $display("test tick done");
        // second boot: the model now hands over a vector with bit 0 clear
        tick_en_i = 1'b0;
        reset_n_i = 1'b0;
        tick(3);
        reset_n_i = 1'b1;
        tick(20);
        `CHK("state bit clear", 1'b0, status_o[24])
        instr_valid_i = 1'b1;
        instr_addr_i = 32'h0000_0100;
        tick(1);
        instr_valid_i = 1'b0;
        wait_exc(cse_pkg::CSE_EXC_FATAL);
        $display("test state bit done");
        stop_test();
    end
endmodule
